// >>> rtl/dca_defines.vh
`ifndef DCA_DEFINES_VH
`define DCA_DEFINES_VH
`define DCA_STATUS_INVALID   8'h80
`define DCA_OP_PERP          8'h12
`define DCA_OP_CONFIGURE     8'h13
`define DCA_OP_DUMP          8'h0E
`define DCA_OP_READ_ID       5'h0A
`define DCA_OP_FORMAT        5'h0D
`define DCA_OP_SEEK          8'h0F
`define DCA_OP_LOCK          5'h14
`define DCA_OP_SPECIFY       8'h03
`define DCA_OP_RECAL         8'h07
`define DCA_OP_SENSE_INT     8'h08
`define DCA_OP_SENSE_DRV     8'h04
`define DCA_OP_VERSION       8'h10
`define DCA_OP_READ          5'h06
`define DCA_OP_READ_DEL      5'h0C
`define DCA_OP_WRITE         5'h05
`define DCA_OP_WRITE_DEL     5'h09
`define DCA_OP_VERIFY        5'h16
`define DCA_OP_READ_TRK      5'h02
`define DCA_XFER_PARAMS      4'h8
`define DCA_XFER_RESULTS     4'h7
`define DCA_DUMP_RESULTS     4'hA
`define DCA_CFG_EIS_BIT      6
`define DCA_STATUS_SEEK_FAIL 8'h70
`define DCA_VERSION_BYTE     8'h90
`endif

// >>> rtl/dca_seek.v
`default_nettype none
module dca_seek #(
  parameter STEP_CYCLES = 16
) (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       enable_i,
  input  wire       start_i,
  input  wire [7:0] target_i,
  input  wire [7:0] present_i,
  input  wire       fail_i,
  output reg        busy_o,
  output reg        done_o,
  output reg        failed_o,
  output reg  [7:0] cyl_o
);
  reg [15:0] cnt_q;

  // -----------------------------------------------------------
  // Steps one cylinder per period toward the target.
  // -----------------------------------------------------------
  always @(posedge clock_i) begin
    if (reset_i) begin
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      failed_o <= 1'b0;
      cyl_o    <= 8'h00;
      cnt_q    <= 16'h0000;
    end else if (enable_i) begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o   <= 1'b1;
        failed_o <= 1'b0;
        cyl_o    <= present_i;
        cnt_q    <= 16'h0000;
      end else if (busy_o) begin
        if (fail_i) begin
          busy_o   <= 1'b0;
          done_o   <= 1'b1;
          failed_o <= 1'b1;
        end else if (cyl_o == target_i) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else if (cnt_q == STEP_CYCLES - 1) begin
          cnt_q <= 16'h0000;
          if (cyl_o < target_i) begin
            cyl_o <= cyl_o + 8'h01;
          end else begin
            cyl_o <= cyl_o - 8'h01;
          end
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dca_core.v
`include "dca_defines.vh"
`default_nettype none
// Operation
// - Unknown opcode acts as no-op, goes standby, returns one byte 80H.
// - Read-identifier reports first good ID field on current cylinder.
// - Dump shared byte: sectors-per-cylinder after format, else end-of-track.
// - Command drive select bits are internal; drive select pins unchanged.
// - Read, write, verify share parameters and results; low five bits differ.
// - With implied seek enabled, seek to commanded cylinder before transfer.
// - Implied seek needs no extra command or result bytes.
// - Addressed drive busy flag set while implied seek runs.
// - Failed seek reported in normal results: error status, failing cylinder.
module dca_core #(
  parameter STEP_CYCLES = 16
) (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       enable_i,
  input  wire       cmd_valid_i,
  input  wire [7:0] cmd_byte_i,
  input  wire       res_read_i,
  input  wire       id_valid_i,
  input  wire       id_error_i,
  input  wire [7:0] id_cyl_i,
  input  wire [7:0] id_head_i,
  input  wire [7:0] id_sector_i,
  input  wire [7:0] id_size_i,
  input  wire       xfer_done_i,
  input  wire       seek_fail_i,
  input  wire [1:0] pin_drive_sel_i,
  output reg        cmd_ready_o,
  output reg        res_valid_o,
  output reg  [7:0] res_byte_o,
  output reg  [3:0] drive_busy_o,
  output reg        standby_o,
  output reg        perp_mode_o,
  output reg        xfer_start_o,
  output reg  [4:0] xfer_op_o,
  output reg  [1:0] drive_sel_o
);
  localparam S_CMD  = 3'd0;
  localparam S_PARM = 3'd1;
  localparam S_SEEK = 3'd2;
  localparam S_EXEC = 3'd3;
  localparam S_RES  = 3'd4;

  reg [2:0] st_q;
  reg [7:0] params_q [0:8];
  reg [3:0] pidx_q;
  reg [3:0] plen_q;
  reg [3:0] ridx_q;
  reg [3:0] rlen_q;
  reg [7:0] res_q [0:9];
  reg [7:0] present_cylinder [0:3];
  reg [7:0] cfg_q;
  reg       implied_seek_q;
  reg       last_fmt_q;
  reg [7:0] sectors_per_cylinder;
  reg [7:0] end_of_track_sector;
  reg [1:0] cur_drive_q;
  reg       seek_start_q;
  reg       lock_q;
  wire      seek_busy;
  wire      seek_done;
  wire      seek_failed;
  wire [7:0] seek_cyl;
  wire [4:0] low5 = params_q[0][4:0];
  wire [7:0] op  = params_q[0];
  wire [1:0] drv = params_q[1][1:0];
  wire [7:0] primary_status_byte = {6'b0000_00, drv} |
             {5'b0000_0, params_q[1][2], 2'b00};
  integer i;

  // -----------------------------------------------------------
  // Seek engine.
  // -----------------------------------------------------------
  dca_seek #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_seek (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .enable_i  (enable_i),
    .start_i   (seek_start_q),
    .target_i  (params_q[2]),
    .present_i (present_cylinder[cur_drive_q]),
    .fail_i    (seek_fail_i),
    .busy_o    (seek_busy),
    .done_o    (seek_done),
    .failed_o  (seek_failed),
    .cyl_o     (seek_cyl)
  );

  function [3:0] param_len;
    input [7:0] b;
    begin
      case (b[4:0])
        `DCA_OP_READ, `DCA_OP_READ_DEL, `DCA_OP_WRITE,
        `DCA_OP_WRITE_DEL, `DCA_OP_VERIFY,
        `DCA_OP_READ_TRK: param_len = `DCA_XFER_PARAMS;
        `DCA_OP_FORMAT: param_len = 4'h5;
        `DCA_OP_READ_ID: param_len = 4'h1;
        default: param_len = 4'h0;
      endcase
      if (b == `DCA_OP_CONFIGURE) param_len = 4'h3;
      if (b == `DCA_OP_SPECIFY) param_len = 4'h2;
      if (b == `DCA_OP_SEEK) param_len = 4'h2;
      if (b == `DCA_OP_RECAL || b == `DCA_OP_SENSE_DRV) param_len = 4'h1;
      if (b == `DCA_OP_PERP) param_len = 4'h1;
    end
  endfunction

  function known_op;
    input [7:0] b;
    begin
      known_op = (param_len(b) != 4'h0) || b == `DCA_OP_DUMP ||
                 b == `DCA_OP_SENSE_INT || b == `DCA_OP_VERSION ||
                 b[6:0] == {2'b00, `DCA_OP_LOCK};
    end
  endfunction

  // -----------------------------------------------------------
  // Command sequencer.
  // -----------------------------------------------------------
  always @(posedge clock_i) begin
    if (reset_i) begin
      st_q <= S_CMD;
      pidx_q <= 4'h0;
      plen_q <= 4'h0;
      ridx_q <= 4'h0;
      rlen_q <= 4'h0;
      cfg_q <= 8'h00;
      implied_seek_q <= 1'b0;
      last_fmt_q <= 1'b0;
      sectors_per_cylinder <= 8'h00;
      end_of_track_sector <= 8'h00;
      cur_drive_q <= 2'b00;
      seek_start_q <= 1'b0;
      lock_q <= 1'b0;
      cmd_ready_o <= 1'b1;
      res_valid_o <= 1'b0;
      res_byte_o <= 8'h00;
      drive_busy_o <= 4'h0;
      standby_o <= 1'b0;
      perp_mode_o <= 1'b0;
      xfer_start_o <= 1'b0;
      xfer_op_o <= 5'h00;
      drive_sel_o <= 2'b00;
      for (i = 0; i < 10; i = i + 1) res_q[i] <= 8'h00;
      for (i = 0; i < 9; i = i + 1) params_q[i] <= 8'h00;
      for (i = 0; i < 4; i = i + 1) present_cylinder[i] <= 8'h00;
    end else if (enable_i) begin
      drive_sel_o <= pin_drive_sel_i;
      xfer_start_o <= 1'b0;
      seek_start_q <= 1'b0;
      case (st_q)
        S_CMD: begin
          if (cmd_valid_i) begin
            params_q[0] <= cmd_byte_i;
            standby_o <= 1'b0;
            if (!known_op(cmd_byte_i)) begin
              res_q[0] <= `DCA_STATUS_INVALID;
              rlen_q <= 4'h1;
              ridx_q <= 4'h0;
              standby_o <= 1'b1;
              cmd_ready_o <= 1'b0;
              st_q <= S_RES;
            end else if (param_len(cmd_byte_i) != 4'h0) begin
              plen_q <= param_len(cmd_byte_i);
              pidx_q <= 4'h1;
              st_q <= S_PARM;
            end else begin
              cmd_ready_o <= 1'b0;
              st_q <= S_EXEC;
            end
          end
        end
        S_PARM: begin
          if (cmd_valid_i) begin
            params_q[pidx_q] <= cmd_byte_i;
            if (pidx_q == plen_q) begin
              cmd_ready_o <= 1'b0;
              cur_drive_q <= params_q[1][1:0];
              if (pidx_q == 4'h1) cur_drive_q <= cmd_byte_i[1:0];
              st_q <= S_EXEC;
            end else begin
              pidx_q <= pidx_q + 4'h1;
            end
          end
        end
        S_EXEC: begin
          ridx_q <= 4'h0;
          rlen_q <= 4'h0;
          st_q <= S_RES;
          if (plen_q == `DCA_XFER_PARAMS && param_len(op) == plen_q) begin
            end_of_track_sector <= params_q[6];
            last_fmt_q <= 1'b0;
            if (implied_seek_q && params_q[2] !=
                present_cylinder[cur_drive_q]) begin
              seek_start_q <= 1'b1;
              drive_busy_o[cur_drive_q] <= 1'b1;
              st_q <= S_SEEK;
            end else begin
              xfer_start_o <= 1'b1;
              xfer_op_o <= low5;
              st_q <= S_SEEK;
            end
          end else if (op[4:0] == `DCA_OP_FORMAT && plen_q == 4'h5) begin
            sectors_per_cylinder <= params_q[3];
            last_fmt_q <= 1'b1;
            for (i = 0; i < 7; i = i + 1) res_q[i] <= 8'h00;
            res_q[0] <= primary_status_byte;
            rlen_q <= 4'h7;
          end else if (op[4:0] == `DCA_OP_READ_ID && plen_q == 4'h1 &&
                       op != `DCA_OP_RECAL) begin
            st_q <= S_EXEC;
            if (id_valid_i && !id_error_i) begin
              res_q[0] <= primary_status_byte;
              res_q[1] <= 8'h00;
              res_q[2] <= 8'h00;
              res_q[3] <= id_cyl_i;
              res_q[4] <= id_head_i;
              res_q[5] <= id_sector_i;
              res_q[6] <= id_size_i;
              rlen_q <= `DCA_XFER_RESULTS;
              st_q <= S_RES;
            end
          end else if (op == `DCA_OP_DUMP) begin
            for (i = 0; i < 4; i = i + 1) res_q[i] <= present_cylinder[i];
            res_q[4] <= params_q[1];
            res_q[5] <= params_q[2];
            res_q[6] <= last_fmt_q ? sectors_per_cylinder
                                   : end_of_track_sector;
            res_q[7] <= {lock_q, 1'b0, perp_mode_o, 5'b0_0000};
            res_q[8] <= cfg_q;
            res_q[9] <= 8'h00;
            rlen_q <= `DCA_DUMP_RESULTS;
          end else if (op == `DCA_OP_CONFIGURE) begin
            cfg_q <= params_q[2];
            implied_seek_q <= params_q[2][`DCA_CFG_EIS_BIT];
          end else if (op == `DCA_OP_PERP) begin
            perp_mode_o <= params_q[1] != 8'h00;
          end else if (op == `DCA_OP_SEEK) begin
            present_cylinder[params_q[1][1:0]] <= params_q[2];
          end else if (op == `DCA_OP_RECAL) begin
            present_cylinder[params_q[1][1:0]] <= 8'h00;
          end else if (op == `DCA_OP_VERSION) begin
            res_q[0] <= `DCA_VERSION_BYTE;
            rlen_q <= 4'h1;
          end else if (op[6:0] == {2'b00, `DCA_OP_LOCK}) begin
            lock_q <= op[7];
            res_q[0] <= {3'b000, op[7], 4'h0};
            rlen_q <= 4'h1;
          end else if (op == `DCA_OP_SENSE_INT) begin
            res_q[0] <= `DCA_STATUS_INVALID;
            res_q[1] <= present_cylinder[cur_drive_q];
            rlen_q <= 4'h2;
          end else if (op == `DCA_OP_SENSE_DRV) begin
            res_q[0] <= {5'b0_0000, params_q[1][2:0]};
            rlen_q <= 4'h1;
          end
        end
        S_SEEK: begin
          if (seek_done) begin
            drive_busy_o[cur_drive_q] <= 1'b0;
            if (seek_failed) begin
              res_q[0] <= `DCA_STATUS_SEEK_FAIL | primary_status_byte;
              res_q[1] <= 8'h00;
              res_q[2] <= 8'h00;
              res_q[3] <= seek_cyl;
              res_q[4] <= params_q[3];
              res_q[5] <= params_q[4];
              res_q[6] <= params_q[5];
              rlen_q <= `DCA_XFER_RESULTS;
              st_q <= S_RES;
            end else begin
              present_cylinder[cur_drive_q] <= seek_cyl;
              xfer_start_o <= 1'b1;
              xfer_op_o <= low5;
            end
          end else if (!seek_busy && !seek_start_q && xfer_done_i) begin
            res_q[0] <= primary_status_byte;
            res_q[1] <= 8'h00;
            res_q[2] <= 8'h00;
            for (i = 3; i < 7; i = i + 1) res_q[i] <= params_q[i - 1];
            rlen_q <= `DCA_XFER_RESULTS;
            st_q <= S_RES;
          end
        end
        S_RES: begin
          if (rlen_q == 4'h0) begin
            res_valid_o <= 1'b0;
            cmd_ready_o <= 1'b1;
            st_q <= S_CMD;
          end else if (!res_valid_o) begin
            res_valid_o <= 1'b1;
            res_byte_o <= res_q[ridx_q];
          end else if (res_read_i) begin
            res_valid_o <= 1'b0;
            if (ridx_q == rlen_q - 4'h1) begin
              cmd_ready_o <= 1'b1;
              st_q <= S_CMD;
            end else begin
              ridx_q <= ridx_q + 4'h1;
            end
          end
        end
        default: st_q <= S_CMD;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> testbench/dca_core_props.sv
`default_nettype none
// ---------------------------------------------------------------
// Port checker for the auxiliary command interpreter.
// ---------------------------------------------------------------
module dca_core_chk #(
  parameter STEP_CYCLES = 16
) (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       enable_i,
  input wire logic       cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic       res_read_i,
  input wire logic       id_valid_i,
  input wire logic       id_error_i,
  input wire logic [7:0] id_cyl_i,
  input wire logic [7:0] id_head_i,
  input wire logic [7:0] id_sector_i,
  input wire logic [7:0] id_size_i,
  input wire logic       xfer_done_i,
  input wire logic       seek_fail_i,
  input wire logic [1:0] pin_drive_sel_i,
  input wire logic       cmd_ready_o,
  input wire logic       res_valid_o,
  input wire logic [7:0] res_byte_o,
  input wire logic [3:0] drive_busy_o,
  input wire logic       standby_o,
  input wire logic       perp_mode_o,
  input wire logic       xfer_start_o,
  input wire logic [4:0] xfer_op_o,
  input wire logic [1:0] drive_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  chk_invalid_code: assert property (
    $rose(standby_o) |=> res_valid_o && res_byte_o == 8'h80)
    else $error("Invalid opcode gave a wrong result.");
  chk_drive_pins: assert property (
    $stable(pin_drive_sel_i) [*3] |-> drive_sel_o == pin_drive_sel_i)
    else $error("Drive select output left its programmed value.");
  chk_seek_first: assert property (
    (|drive_busy_o) |-> !xfer_start_o)
    else $error("Transfer started during the seek.");
  chk_busy_single: assert property (
    $onehot0(drive_busy_o))
    else $error("More than one drive busy.");
  chk_seek_silent: assert property (
    (|drive_busy_o) |-> !res_valid_o && !cmd_ready_o)
    else $error("Bytes exchanged during the seek.");
  chk_result_hold: assert property (
    res_valid_o && !res_read_i |=> res_valid_o && $stable(res_byte_o))
    else $error("Result byte withdrawn before it was read.");
  chk_no_overlap: assert property (
    res_valid_o |-> !cmd_ready_o)
    else $error("Command accepted during the result phase.");
  chk_read_drop: assert property (
    enable_i && res_valid_o && res_read_i |=> !res_valid_o)
    else $error("Result valid did not drop after a read.");
  chk_start_pulse: assert property (
    xfer_start_o |=> !xfer_start_o)
    else $error("Transfer start longer than one cycle.");
  chk_op_code: assert property (
    xfer_start_o |-> xfer_op_o inside
      {5'h06, 5'h0C, 5'h05, 5'h09, 5'h16, 5'h02, 5'h0D})
    else $error("Transfer started with an unknown operation.");
endmodule
bind dca_core dca_core_chk #(.STEP_CYCLES(STEP_CYCLES)) dca_core_chk_inst (
  .clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
  .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i),
  .res_read_i(res_read_i), .id_valid_i(id_valid_i),
  .id_error_i(id_error_i), .id_cyl_i(id_cyl_i), .id_head_i(id_head_i),
  .id_sector_i(id_sector_i), .id_size_i(id_size_i),
  .xfer_done_i(xfer_done_i), .seek_fail_i(seek_fail_i),
  .pin_drive_sel_i(pin_drive_sel_i), .cmd_ready_o(cmd_ready_o),
  .res_valid_o(res_valid_o), .res_byte_o(res_byte_o),
  .drive_busy_o(drive_busy_o), .standby_o(standby_o),
  .perp_mode_o(perp_mode_o), .xfer_start_o(xfer_start_o),
  .xfer_op_o(xfer_op_o), .drive_sel_o(drive_sel_o));
`default_nettype wire

// >>> testbench/dca_media_model.sv
`default_nettype none
// ---------------------------------------------------------------
// Drive and media side: ID fields, transfer end, seek errors.
// ---------------------------------------------------------------
module dca_media_model #(
  parameter int DONE_DELAY = 5
) (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       xfer_start_i,
  input  wire logic [3:0] busy_i,
  input  wire logic       fail_req_i,
  output logic            xfer_done_o,
  output logic            seek_fail_o,
  output logic            id_valid_o,
  output logic            id_error_o,
  output logic [7:0]      id_cyl_o,
  output logic [7:0]      id_head_o,
  output logic [7:0]      id_sector_o,
  output logic [7:0]      id_size_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tick_q;
  logic [7:0] wait_q;
  logic       good;
  always @(posedge clock_i) begin
    if (reset_i) begin
      tick_q <= 4'h0;
      wait_q <= 8'h00;
    end else begin
      tick_q <= tick_q + 4'h1;
      if (xfer_start_i) wait_q <= 8'(DONE_DELAY);
      else if (wait_q != 8'h00) wait_q <= wait_q - 8'h01;
    end
  end
  // Errored and good ID fields alternate; fields churn between them.
  assign id_valid_o  = tick_q[2:0] == 3'h7;
  assign id_error_o  = id_valid_o & ~tick_q[3];
  assign good        = id_valid_o & tick_q[3];
  assign id_cyl_o    = good ? 8'h07 : {4'h5, tick_q};
  assign id_head_o   = good ? 8'h00 : {4'hA, tick_q};
  assign id_sector_o = good ? 8'h04 : {4'h6, tick_q};
  assign id_size_o   = good ? 8'h02 : {4'h9, tick_q};
  assign xfer_done_o = wait_q == 8'h01;
  assign seek_fail_o = fail_req_i & (|busy_i);
endmodule
`default_nettype wire

// >>> testbench/dca_core_tb_top.sv
`default_nettype none
// ---------------------------------------------------------------
// Command sequences through the byte port with expected results.
// ---------------------------------------------------------------
module dca_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i, reset_i, enable_i, cmd_valid_i, res_read_i;
  logic [7:0] cmd_byte_i, id_cyl_i, id_head_i, id_sector_i, id_size_i;
  logic       id_valid_i, id_error_i, xfer_done_i, seek_fail_i, fail_req;
  logic [1:0] pin_drive_sel_i, drive_sel_o;
  logic       cmd_ready_o, res_valid_o, standby_o, perp_mode_o;
  logic       xfer_start_o, saw_busy, saw_start;
  logic [7:0] res_byte_o;
  logic [3:0] drive_busy_o;
  logic [4:0] xfer_op_o, op_seen;
  logic [7:0] r [0:9];
  int         miscompares = 0, compares = 0, cycles = 0;
  dca_core #(.STEP_CYCLES(2)) dca_core_inst (
    .clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
    .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i),
    .res_read_i(res_read_i), .id_valid_i(id_valid_i),
    .id_error_i(id_error_i), .id_cyl_i(id_cyl_i), .id_head_i(id_head_i),
    .id_sector_i(id_sector_i), .id_size_i(id_size_i),
    .xfer_done_i(xfer_done_i), .seek_fail_i(seek_fail_i),
    .pin_drive_sel_i(pin_drive_sel_i), .cmd_ready_o(cmd_ready_o),
    .res_valid_o(res_valid_o), .res_byte_o(res_byte_o),
    .drive_busy_o(drive_busy_o), .standby_o(standby_o),
    .perp_mode_o(perp_mode_o), .xfer_start_o(xfer_start_o),
    .xfer_op_o(xfer_op_o), .drive_sel_o(drive_sel_o));
  dca_media_model dca_media_model_inst (
    .clock_i(clock_i), .reset_i(reset_i), .xfer_start_i(xfer_start_o),
    .busy_i(drive_busy_o), .fail_req_i(fail_req),
    .xfer_done_o(xfer_done_i), .seek_fail_o(seek_fail_i),
    .id_valid_o(id_valid_i), .id_error_o(id_error_i),
    .id_cyl_o(id_cyl_i), .id_head_o(id_head_i),
    .id_sector_o(id_sector_i), .id_size_o(id_size_i));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (drive_busy_o[1]) saw_busy <= 1'b1;
    if (xfer_start_o) saw_start <= 1'b1;
    if (xfer_start_o) op_seen <= xfer_op_o;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 500) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 500) begin
      miscompares++;
      $display("[ERR] %0t command port never ready", $time);
    end
    cmd_byte_i = b;
    cmd_valid_i = 1'b1;
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic get(input int cnt);
    int n;
    for (int i = 0; i < cnt; i++) begin
      n = 0;
      while (res_valid_o !== 1'b1 && n < 500) begin
        @(negedge clock_i);
        n++;
      end
      if (n == 500) begin
        miscompares++;
        $display("[ERR] %0t result byte never offered", $time);
      end
      r[i] = res_byte_o;
      res_read_i = 1'b1;
      @(negedge clock_i);
      res_read_i = 1'b0;
    end
  endtask
  task automatic xfer(input logic [7:0] op, input logic [7:0] cyl,
                      input logic fail, input logic sk);
    saw_busy = 1'b0;
    saw_start = 1'b0;
    put(op);
    put(8'h01);
    put(cyl);
    put(8'h00);
    put(8'h01);
    put(8'h02);
    put(8'h09);
    put(8'h1B);
    put(8'hFF);
    get(7);
    cmp_flag(saw_busy, sk);
    if (fail) begin
      cmp_byte(r[0], 8'h71);
      cmp_flag(saw_start, 1'b0);
    end else begin
      cmp_byte(r[0], 8'h01);
      cmp_byte(r[3], cyl);
      cmp_byte(r[6], 8'h02);
      cmp_byte({3'h0, op_seen}, {3'h0, op[4:0]});
    end
  endtask
  initial begin
    reset_i = 1'b1;
    enable_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_byte_i = 8'h00;
    res_read_i = 1'b0;
    fail_req = 1'b0;
    pin_drive_sel_i = 2'b10;
    saw_busy = 1'b0;
    saw_start = 1'b0;
    op_seen = 5'h00;
    repeat (4) @(negedge clock_i);
    reset_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      put(i == 0 ? 8'h00 : 8'hFF);
      get(1);
      cmp_byte(r[0], 8'h80);
      cmp_flag(standby_o, 1'b1);
    end
    $display("test invalid_opcode done");
    put(8'h12);
    put(8'h03);
    repeat (4) @(negedge clock_i);
    cmp_flag(perp_mode_o, 1'b1);
    $display("test perpendicular done");
    put(8'h13);
    put(8'h00);
    put(8'h40);
    put(8'h00);
    xfer(8'h46, 8'h05, 1'b0, 1'b1);
    pin_drive_sel_i = 2'b11;
    xfer(8'h45, 8'h03, 1'b0, 1'b1);
    xfer(8'h56, 8'h07, 1'b0, 1'b1);
    cmp_byte({6'h00, drive_sel_o}, 8'h03);
    $display("test transfers done");
    put(8'h0E);
    enable_i = 1'b0;
    repeat (6) @(negedge clock_i);
    cmp_flag(res_valid_o, 1'b0);
    cmp_flag(cmd_ready_o, 1'b0);
    enable_i = 1'b1;
    get(10);
    cmp_byte(r[1], 8'h07);
    cmp_byte(r[6], 8'h09);
    $display("test dump done");
    put(8'h4A);
    put(8'h01);
    get(7);
    cmp_byte(r[3], 8'h07);
    cmp_byte(r[5], 8'h04);
    $display("test read_id done");
    fail_req = 1'b1;
    xfer(8'h46, 8'h09, 1'b1, 1'b1);
    fail_req = 1'b0;
    cmp_byte(r[3], 8'h07);
    xfer(8'h46, 8'h07, 1'b0, 1'b0);
    $display("test seek_fail done");
    put(8'h4D);
    put(8'h01);
    put(8'h02);
    put(8'h12);
    put(8'h1B);
    put(8'hE5);
    get(7);
    put(8'h0E);
    get(10);
    cmp_byte(r[6], 8'h12);
    $display("test format_dump done");
    summarize();
  end
endmodule
`default_nettype wire
